// file: hdl/mbde_slave.sv
// Purpose: Slave end: answers diagnostics by echo and reads of holding registers.
// Assumes: The master keeps its rules: no broadcast diagnostics, frames byte-wise.
// Notes:   Register values come from a user-side lookup port answered in the same cycle.
`timescale 1ns/1ps
module mbde_slave #(
    parameter int QBUF = 8
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    mbde_if.slave            link,
    input  wire logic [7:0]  station_addr,
    input  wire logic        word_endian_select_param,
    output logic      [15:0] reg_addr,
    input  wire logic [31:0] reg_value,
    input  wire logic [1:0]  reg_size,
    output logic             comm_error,
    output logic             diag_seen
);
    if (QBUF < mbde_pkg::READ_QLEN) begin : g_qbuf_check
        $error("QBUF too small");
    end

    typedef enum {ST_RX, ST_CHECK, ST_TX, ST_SKIP} mbde_state_t;

    mbde_state_t  state_ff,  nxt_state;
    logic [7:0]   qbuf_ff [QBUF];
    logic [7:0]   nxt_qbuf [QBUF];
    logic [7:0]   qcnt_ff,   nxt_qcnt;
    logic [15:0]  crc_ff,    nxt_crc;
    logic [7:0]   tidx_ff,   nxt_tidx;
    logic [7:0]   tlen_ff,   nxt_tlen;
    logic [15:0]  raddr_ff,  nxt_raddr;
    logic [7:0]   wpart_ff,  nxt_wpart;
    logic         err_ff,    nxt_err;
    logic         diag_ff,   nxt_diag;
    logic         over_ff,   nxt_over;

    // ==================================================================
    // Response byte source
    // ==================================================================
    // Word within a register: 4-byte values split in two per the endian setting.
    function automatic logic [15:0] reg_word(input logic [31:0] v, input logic [1:0] sz,
                                             input logic part, input logic endian);
        logic [15:0] w;
        w = 16'h0000;
        if (sz == 2'd1) begin
            w = {8'h00, v[7:0]};
        end else if (sz == 2'd2) begin
            w = v[15:0];
        end else begin
            w = (part ^ endian) ? v[31:16] : v[15:0];
        end
        return w;
    endfunction : reg_word

    logic [15:0] cur_word;
    logic [7:0]  cur_byte;
    logic        is_diag;
    always_comb begin
        is_diag  = (qbuf_ff[1] == mbde_pkg::FC_DIAG);
        reg_addr = raddr_ff;
        cur_word = reg_word(reg_value, reg_size, wpart_ff[1], word_endian_select_param);
        cur_byte = 8'h00;
        if (tidx_ff == 8'd0) begin
            cur_byte = station_addr;
        end else if (tidx_ff == 8'd1) begin
            cur_byte = qbuf_ff[1];
        end else if (tidx_ff + 8'd2 >= tlen_ff) begin
            cur_byte = (tidx_ff + 8'd2 == tlen_ff) ? crc_ff[7:0] : crc_ff[15:8];
        end else if (is_diag) begin
            // Fields 2..3 are sent as zero, the checked sub-function; 4..5 are the query bytes, so the echo is exact.
            cur_byte = (tidx_ff < 8'd4) ? 8'h00 : qbuf_ff[tidx_ff[2:0]];
        end else if (tidx_ff == 8'd2) begin
            cur_byte = {qbuf_ff[5][6:0], 1'b0};
        end else begin
            cur_byte = wpart_ff[0] ? cur_word[7:0] : cur_word[15:8];
        end
    end

    assign link.q_ready = (state_ff == ST_RX) || (state_ff == ST_SKIP);
    assign link.r_valid = (state_ff == ST_TX);
    assign link.r_data  = cur_byte;
    assign link.r_last  = (state_ff == ST_TX) && (tidx_ff + 8'd1 == tlen_ff);
    assign comm_error   = err_ff;
    assign diag_seen    = diag_ff;

    // ==================================================================
    // Frame engine
    // ==================================================================
    always_comb begin
        nxt_state = state_ff;
        nxt_qbuf  = qbuf_ff;
        nxt_qcnt  = qcnt_ff;
        nxt_crc   = crc_ff;
        nxt_tidx  = tidx_ff;
        nxt_tlen  = tlen_ff;
        nxt_raddr = raddr_ff;
        nxt_wpart = wpart_ff;
        nxt_err   = 1'b0;
        nxt_diag  = 1'b0;
        nxt_over  = over_ff;
        unique case (state_ff)
            ST_RX: begin
                if (link.q_valid) begin
                    if (qcnt_ff < 8'(QBUF)) begin
                        nxt_qbuf[qcnt_ff[2:0]] = link.q_data;
                    end else begin
                        nxt_over = 1'b1;
                    end
                    nxt_qcnt = qcnt_ff + 8'd1;
                    nxt_crc  = mbde_pkg::crc_byte(crc_ff, link.q_data);
                    if (link.q_last) begin
                        nxt_state = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                nxt_state = ST_RX;
                nxt_qcnt  = 8'd0;
                nxt_crc   = mbde_pkg::CRC_INIT;
                nxt_tidx  = 8'd0;
                nxt_wpart = 8'd0;
                nxt_over  = 1'b0;
                nxt_raddr = {qbuf_ff[2], qbuf_ff[3]};
                if (crc_ff == mbde_pkg::CRC_RESIDUE && !over_ff
                    && qcnt_ff == 8'(mbde_pkg::DIAG_LEN)
                    && qbuf_ff[0] == station_addr) begin
                    if (is_diag) begin
                        if ({qbuf_ff[2], qbuf_ff[3]} != mbde_pkg::DIAG_SUB_ECHO) begin
                            nxt_err = 1'b1;
                        end else begin
                            nxt_diag  = 1'b1;
                            nxt_tlen  = 8'(mbde_pkg::DIAG_LEN);
                            nxt_state = ST_TX;
                        end
                    end else if (qbuf_ff[1] == mbde_pkg::FC_READ_HOLD && qbuf_ff[4] == 8'h00
                                 && qbuf_ff[5] != 8'h00 && qbuf_ff[5] < 8'd64) begin
                        nxt_tlen  = qbuf_ff[5] * 8'd2 + 8'd5;
                        nxt_state = ST_TX;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
            end
            ST_TX: begin
                if (link.r_ready) begin
                    nxt_tidx = tidx_ff + 8'd1;
                    // The CRC bytes themselves must not feed the running CRC.
                    if (tidx_ff + 8'd2 < tlen_ff) begin
                        nxt_crc = mbde_pkg::crc_byte(crc_ff, cur_byte);
                    end
                    if (!is_diag && tidx_ff >= 8'd3 && tidx_ff + 8'd2 < tlen_ff) begin
                        nxt_wpart = wpart_ff + 8'd1;
                        // A 4-byte register spans two points but only one index.
                        if (wpart_ff[0] && (reg_size != 2'd3 || wpart_ff[1])) begin
                            nxt_raddr = raddr_ff + 16'd1;
                            nxt_wpart = 8'd0;
                        end
                    end
                    if (tidx_ff + 8'd1 == tlen_ff) begin
                        nxt_state = ST_RX;
                        nxt_crc   = mbde_pkg::CRC_INIT;
                    end
                end
            end
            default: begin
                nxt_state = ST_RX;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= ST_RX;
            for (int i = 0; i < QBUF; i++) begin
                qbuf_ff[i] <= 8'h00;
            end
            qcnt_ff  <= 8'd0;
            crc_ff   <= mbde_pkg::CRC_INIT;
            tidx_ff  <= 8'd0;
            tlen_ff  <= 8'd0;
            raddr_ff <= 16'h0000;
            wpart_ff <= 8'd0;
            err_ff   <= 1'b0;
            diag_ff  <= 1'b0;
            over_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            qbuf_ff  <= nxt_qbuf;
            qcnt_ff  <= nxt_qcnt;
            crc_ff   <= nxt_crc;
            tidx_ff  <= nxt_tidx;
            tlen_ff  <= nxt_tlen;
            raddr_ff <= nxt_raddr;
            wpart_ff <= nxt_wpart;
            err_ff   <= nxt_err;
            diag_ff  <= nxt_diag;
            over_ff  <= nxt_over;
        end
    end
endmodule : mbde_slave

// file: hdl/mbde_pkg.sv
// Purpose: Shared constants and the CRC function for the diagnostic echo slave and its master end.
// Assumes: Frames move as bytes; the serial character timing lies outside these blocks.
// Notes:   Every frame ends with a CRC sent low byte first.
package mbde_pkg;
    // ==================================================================
    // Function codes and field values
    // ==================================================================
    localparam logic [7:0]  FC_READ_HOLD   = 8'h03;
    localparam logic [7:0]  FC_DIAG        = 8'h08;
    localparam logic [15:0] DIAG_SUB_ECHO  = 16'h0000;
    localparam logic [7:0]  ADDR_BROADCAST = 8'h00;
    localparam logic [15:0] CRC_INIT       = 16'hffff;
    localparam logic [15:0] CRC_POLY       = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE    = 16'h0000;
    localparam int          DIAG_LEN       = 8;
    localparam int          READ_QLEN      = 8;
    localparam int          RESP_MAX       = 64;
    localparam logic [7:0]  ADDR_RESET     = 8'h01;
    localparam logic        ENDIAN_RESET   = 1'b0;

    // One byte of CRC-16 update, reflected polynomial.
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte
endpackage : mbde_pkg

// file: hdl/mbde_if.sv
// Purpose: Byte link between the master end and the slave end.
// Assumes: One byte moves in a cycle where valid and ready are both high.
// Notes:   The last byte of a frame carries last.
`timescale 1ns/1ps
interface mbde_if;
    logic [7:0] q_data;
    logic       q_valid;
    logic       q_last;
    logic       q_ready;
    logic [7:0] r_data;
    logic       r_valid;
    logic       r_last;
    logic       r_ready;

    modport master (output q_data, output q_valid, output q_last, input q_ready,
                    input r_data, input r_valid, input r_last, output r_ready);
    modport slave  (input q_data, input q_valid, input q_last, output q_ready,
                    output r_data, output r_valid, output r_last, input r_ready);
endinterface : mbde_if

// file: hdl/mbde_master.sv
// Purpose: Master end: sends one diagnostics query and checks the echo.
// Assumes: The slave answers every valid individual query.
// Notes:   Broadcast station is refused before any byte is sent.
`timescale 1ns/1ps
module mbde_master (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    mbde_if.master           link,
    input  wire logic        start,
    input  wire logic [7:0]  target_addr,
    input  wire logic [15:0] probe_data,
    output logic             busy,
    output logic             done,
    output logic             echo_ok
);
    typedef enum {MS_IDLE, MS_SEND, MS_RECV} mbde_mstate_t;

    mbde_mstate_t state_ff, nxt_state;
    logic [2:0]   idx_ff,   nxt_idx;
    logic [15:0]  crc_ff,   nxt_crc;
    logic [7:0]   frame_ff [8];
    logic [7:0]   nxt_frame [8];
    logic         ok_ff,    nxt_ok;
    logic         done_ff,  nxt_done;
    logic [7:0]   out_byte;

    // ==================================================================
    // Query bytes
    // ==================================================================
    always_comb begin
        out_byte = frame_ff[idx_ff];
        if (idx_ff == 3'd6) begin
            out_byte = crc_ff[7:0];
        end else if (idx_ff == 3'd7) begin
            out_byte = crc_ff[15:8];
        end
    end

    assign link.q_valid = (state_ff == MS_SEND);
    assign link.q_data  = out_byte;
    assign link.q_last  = (idx_ff == 3'd7);
    assign link.r_ready = (state_ff == MS_RECV);
    assign busy         = (state_ff != MS_IDLE);
    assign done         = done_ff;
    assign echo_ok      = ok_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_idx   = idx_ff;
        nxt_crc   = crc_ff;
        nxt_frame = frame_ff;
        nxt_ok    = ok_ff;
        nxt_done  = 1'b0;
        unique case (state_ff)
            MS_IDLE: begin
                if (start && target_addr != mbde_pkg::ADDR_BROADCAST) begin
                    nxt_frame[0] = target_addr;
                    nxt_frame[1] = mbde_pkg::FC_DIAG;
                    nxt_frame[2] = mbde_pkg::DIAG_SUB_ECHO[15:8];
                    nxt_frame[3] = mbde_pkg::DIAG_SUB_ECHO[7:0];
                    nxt_frame[4] = probe_data[15:8];
                    nxt_frame[5] = probe_data[7:0];
                    nxt_idx   = 3'd0;
                    nxt_crc   = mbde_pkg::CRC_INIT;
                    nxt_state = MS_SEND;
                end
            end
            MS_SEND: begin
                if (link.q_ready) begin
                    if (idx_ff < 3'd6) begin
                        nxt_crc = mbde_pkg::crc_byte(crc_ff, out_byte);
                    end
                    nxt_idx = idx_ff + 3'd1;
                    if (idx_ff == 3'd7) begin
                        nxt_state = MS_RECV;
                        nxt_crc   = mbde_pkg::CRC_INIT;
                        nxt_ok    = 1'b1;
                        nxt_idx   = 3'd0;
                    end
                end
            end
            MS_RECV: begin
                if (link.r_valid) begin
                    nxt_crc = mbde_pkg::crc_byte(crc_ff, link.r_data);
                    if (idx_ff < 3'd6 && link.r_data != frame_ff[idx_ff]) begin
                        nxt_ok = 1'b0;
                    end
                    nxt_idx = idx_ff + 3'd1;
                    if (link.r_last) begin
                        if (idx_ff != 3'd7 || nxt_crc != mbde_pkg::CRC_RESIDUE) begin
                            nxt_ok = 1'b0;
                        end
                        nxt_done  = 1'b1;
                        nxt_state = MS_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = MS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= MS_IDLE;
            idx_ff   <= 3'd0;
            crc_ff   <= mbde_pkg::CRC_INIT;
            for (int i = 0; i < 8; i++) begin
                frame_ff[i] <= 8'h00;
            end
            ok_ff    <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idx_ff   <= nxt_idx;
            crc_ff   <= nxt_crc;
            frame_ff <= nxt_frame;
            ok_ff    <= nxt_ok;
            done_ff  <= nxt_done;
        end
    end
endmodule : mbde_master

// file: verification/mbde_checker.sv
// Purpose: Concurrent checks on the byte link between the master end and the slave end.
// Assumes: Only diagnostics frames cross this link, one query at a time.
// Notes:   Query bytes are kept so that every answer byte is tied to its cause.
`timescale 1ns/1ps
module mbde_checker (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] q_data,
    input wire logic       q_valid,
    input wire logic       q_last,
    input wire logic       q_ready,
    input wire logic [7:0] r_data,
    input wire logic       r_valid,
    input wire logic       r_last,
    input wire logic       r_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ==================================================================
    // Frame position tracking
    // ==================================================================
    logic [7:0] qbuf_ff  [8];
    logic [7:0] nxt_qbuf [8];
    logic [2:0] qcnt_ff;
    logic [2:0] nxt_qcnt;
    logic [2:0] rcnt_ff;
    logic [2:0] nxt_rcnt;

    always_comb begin
        nxt_qbuf = qbuf_ff;
        nxt_qcnt = qcnt_ff;
        nxt_rcnt = rcnt_ff;
        if (q_valid && q_ready) begin
            nxt_qbuf[qcnt_ff] = q_data;
            nxt_qcnt = q_last ? 3'h0 : qcnt_ff + 3'h1;
        end
        if (r_valid && r_ready) begin
            nxt_rcnt = r_last ? 3'h0 : rcnt_ff + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        qbuf_ff <= nxt_qbuf;
        qcnt_ff <= rst_n ? nxt_qcnt : 3'h0;
        rcnt_ff <= rst_n ? nxt_rcnt : 3'h0;
    end

    // ==================================================================
    // Properties
    // ==================================================================
    sequence s_qend;
        q_valid && q_ready && q_last;
    endsequence
    sequence s_wait_answer;
        !r_valid ##1 !r_valid ##1 r_valid;
    endsequence

    property p_answer_time;
        s_qend |-> s_wait_answer;
    endproperty
    property p_resp_hold;
        r_valid && !r_ready |=> r_valid && $stable(r_data) && $stable(r_last);
    endproperty
    property p_echo;
        r_valid && r_ready |-> r_data == qbuf_ff[rcnt_ff];
    endproperty
    property p_station;
        r_valid && rcnt_ff == 3'h0 |-> r_data == qbuf_ff[0];
    endproperty
    property p_func;
        r_valid && rcnt_ff == 3'h1 |-> r_data == mbde_pkg::FC_DIAG;
    endproperty
    property p_sub_zero;
        r_valid && (rcnt_ff == 3'h2 || rcnt_ff == 3'h3) |-> r_data == 8'h00;
    endproperty
    property p_frame_len;
        r_valid && r_ready && r_last |-> rcnt_ff == 3'h7;
    endproperty
    property p_no_bcast;
        q_valid && qcnt_ff == 3'h0 |-> q_data != mbde_pkg::ADDR_BROADCAST;
    endproperty
    property p_query_sub;
        q_valid && (qcnt_ff == 3'h2 || qcnt_ff == 3'h3) |-> q_data == 8'h00;
    endproperty
    property p_query_hold;
        q_valid && !q_ready |=> q_valid && $stable(q_data) && $stable(q_last);
    endproperty

    a_answer_time: assert property (p_answer_time)
        else $error("answer not two cycles after the last query byte");
    a_resp_hold: assert property (p_resp_hold)
        else $error("answer byte changed before it was taken");
    a_echo: assert property (p_echo)
        else $error("answer byte differs from the query byte");
    a_station: assert property (p_station)
        else $error("first answer byte is not the station number");
    a_func: assert property (p_func)
        else $error("answer function code wrong");
    a_sub_zero: assert property (p_sub_zero)
        else $error("answer sub-function not zero");
    a_frame_len: assert property (p_frame_len)
        else $error("answer frame length wrong");
    a_no_bcast: assert property (p_no_bcast)
        else $error("diagnostics query sent to broadcast station");
    a_query_sub: assert property (p_query_sub)
        else $error("query sub-function not zero");
    a_query_hold: assert property (p_query_hold)
        else $error("query byte changed before it was taken");
endmodule : mbde_checker

// file: verification/test_modbus_rtu_diagnostic_echo.sv
// Purpose: Drives both ends of the echo link and a lone slave fed by the bench.
// Assumes: The slave answers two cycles after the last query byte.
// Notes:   The lone slave takes frames that the master end can never make.
`timescale 1ns/1ps
module test_modbus_rtu_diagnostic_echo;
    logic        clk_sys;
    logic        rst_n;
    int          err_total;
    int          comparisons;
    int          seed;
    logic [31:0] rnd;
    logic [7:0]  st1;
    logic [7:0]  st2;
    logic        end2;
    logic        start;
    logic [7:0]  target_addr;
    logic [15:0] probe_data;
    logic        done;
    logic        echo_ok;
    logic [15:0] ra1;
    logic [15:0] ra2;
    logic        cerr2;
    logic        dseen2;
    logic        cerr_seen;
    logic        dseen_seen;
    logic        busy;
    int          cerr_cnt = 0;
    int          dseen_cnt = 0;
    logic [7:0]  qf[$];
    logic [7:0]  ef[$];
    logic [7:0]  rf[$];

    // ==================================================================
    // Register space model and reference arithmetic
    // ==================================================================
    function automatic logic [1:0] size_of(input logic [15:0] a);
        return (a[1:0] == 2'h0) ? 2'h3 : ((a[1:0] == 2'h1) ? 2'h1 : 2'h2);
    endfunction : size_of
    // Upper bits are never clear, so a missing zero-extension shows up.
    function automatic logic [31:0] val_of(input logic [15:0] a);
        return {a ^ 16'h9c35, ~a};
    endfunction : val_of
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
        end
        return r;
    endfunction : crc16

    mbde_if i1 ();
    mbde_if i2 ();
    mbde_master i_mbde_master (.clk_sys(clk_sys), .rst_n(rst_n), .link(i1), .start(start),
        .target_addr(target_addr), .probe_data(probe_data), .busy(busy), .done(done),
        .echo_ok(echo_ok));
    mbde_slave i_mbde_slave (.clk_sys(clk_sys), .rst_n(rst_n), .link(i1), .station_addr(st1),
        .word_endian_select_param(1'b0), .reg_addr(ra1), .reg_value(val_of(ra1)),
        .reg_size(size_of(ra1)), .comm_error(), .diag_seen());
    mbde_slave i_mbde_slave_2 (.clk_sys(clk_sys), .rst_n(rst_n), .link(i2),
        .station_addr(st2), .word_endian_select_param(end2), .reg_addr(ra2),
        .reg_value(val_of(ra2)), .reg_size(size_of(ra2)), .comm_error(cerr2),
        .diag_seen(dseen2));
    mbde_checker i_mbde_checker (.clk_sys(clk_sys), .rst_n(rst_n), .q_data(i1.q_data),
        .q_valid(i1.q_valid), .q_last(i1.q_last), .q_ready(i1.q_ready), .r_data(i1.r_data),
        .r_valid(i1.r_valid), .r_last(i1.r_last), .r_ready(i1.r_ready));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (cerr2 === 1'b1) cerr_cnt <= cerr_cnt + 1;
        if (dseen2 === 1'b1) dseen_cnt <= dseen_cnt + 1;
    end

    // ==================================================================
    // Tasks
    // ==================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic add_crc(ref logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[k]) c = crc16(c, q[k]);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endtask : add_crc

    task automatic mk_diag(input logic [7:0] st, input logic [15:0] sub, input logic [15:0] d);
        qf = {st, 8'h08, sub[15:8], sub[7:0], d[15:8], d[7:0]};
        add_crc(qf);
        ef = qf;
    endtask : mk_diag

    task automatic mk_read(input logic [15:0] sa, input int nreg);
        logic [15:0] pts;
        logic [15:0] a;
        logic [31:0] v;
        logic [7:0]  bc;
        pts = 16'h0000;
        ef = {};
        for (int k = 0; k < nreg; k++) begin
            a = sa + 16'(k);
            v = val_of(a);
            pts = pts + ((size_of(a) == 2'h3) ? 16'h0002 : 16'h0001);
            case (size_of(a))
                2'h3: if (end2) ef = {ef, v[31:24], v[23:16], v[15:8], v[7:0]};
                      else ef = {ef, v[15:8], v[7:0], v[31:24], v[23:16]};
                2'h1: ef = {ef, 8'h00, v[7:0]};
                default: ef = {ef, v[15:8], v[7:0]};
            endcase
        end
        bc = {pts[6:0], 1'b0};
        qf = {st2, 8'h03, sa[15:8], sa[7:0], pts[15:8], pts[7:0]};
        add_crc(qf);
        ef = {st2, 8'h03, bc, ef};
        add_crc(ef);
    endtask : mk_read

    // Sends qf to the lone slave, gathers its answer with a stalling reader, compares with ef.
    task automatic run2;
        int n;
        int c0;
        int d0;
        c0 = cerr_cnt;
        d0 = dseen_cnt;
        rf = {};
        foreach (qf[k]) begin
            @(negedge clk_sys);
            i2.q_data = qf[k];
            i2.q_valid = 1'b1;
            i2.q_last = (k == qf.size() - 1);
            n = 0;
            while (i2.q_ready !== 1'b1 && n < 50) begin
                @(negedge clk_sys);
                n++;
            end
            if (n == 50) chk(32'h0, 32'h1);
        end
        @(negedge clk_sys);
        i2.q_valid = 1'b0;
        i2.q_last = 1'b0;
        for (n = 0; n < 80; n++) begin
            rnd = $random(seed);
            i2.r_ready = rnd[0] | rnd[1];
            if (i2.r_valid === 1'b1 && i2.r_ready) begin
                rf.push_back(i2.r_data);
                if (i2.r_last === 1'b1) break;
            end
            @(negedge clk_sys);
        end
        chk(rf.size(), ef.size());
        foreach (ef[k]) if (k < rf.size()) chk(rf[k], ef[k]);
        cerr_seen = (cerr_cnt != c0);
        dseen_seen = (dseen_cnt != d0);
    endtask : run2

    task automatic probe(input logic [7:0] t, input logic [15:0] d);
        int n;
        @(negedge clk_sys);
        st1 = t;
        target_addr = t;
        probe_data = d;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        chk(busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 100) chk(32'h0, 32'h1);
        chk(echo_ok, 1'b1);
        chk(busy, 1'b0);
    endtask : probe

    // ==================================================================
    // Main sequence
    // ==================================================================
    initial begin
        seed = 32'h30e3c656;
        err_total = 0;
        comparisons = 0;
        rst_n = 1'b0;
        start = 1'b0;
        target_addr = 8'h01;
        probe_data = 16'h0000;
        st1 = 8'h03;
        st2 = 8'h5a;
        end2 = 1'b0;
        i2.q_data = 8'h00;
        i2.q_valid = 1'b0;
        i2.q_last = 1'b0;
        i2.r_ready = 1'b0;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        probe(8'h03, 16'h1234);
        probe(8'hff, 16'hffff);
        for (int k = 0; k < 8; k++) begin
            rnd = $random(seed);
            probe(rnd[7:0] | 8'h01, rnd[31:16]);
        end
        for (int k = 0; k < 6; k++) begin
            rnd = $random(seed);
            st2 = (k == 0) ? 8'hff : (rnd[7:0] | 8'h01);
            mk_diag(st2, 16'h0000, rnd[31:16]);
            run2;
            chk(dseen_seen, 1'b1);
            mk_diag(st2, (k < 2) ? (16'h0001 << (8 * k)) : (rnd[15:0] | 16'h0010), rnd[31:16]);
            ef = {};
            run2;
            chk(cerr_seen, 1'b1);
            mk_diag(st2, 16'h0000, rnd[15:0]);
            qf[6 + k % 2] = qf[6 + k % 2] ^ 8'h01;
            ef = {};
            run2;
            chk(cerr_seen, 1'b0);
            mk_diag((k % 2) ? 8'h00 : (st2 ^ 8'h80), 16'h0000, rnd[15:0]);
            ef = {};
            run2;
        end
        for (int k = 0; k < 12; k++) begin
            rnd = $random(seed);
            end2 = k[0];
            if (k < 2) mk_read(16'h2b04, 1);
            else mk_read(rnd[15:0] & 16'h7fff, 1 + int'(rnd[17:16]));
            run2;
        end
        @(negedge clk_sys);
        target_addr = 8'h00;
        start = 1'b1;
        for (int k = 0; k < 20; k++) begin
            @(negedge clk_sys);
            start = 1'b0;
            chk(i1.q_valid, 1'b0);
            chk(busy, 1'b0);
        end
        end_sim;
    end

    // A hang is cut short here and reported like any other mismatch.
    initial begin
        repeat (90000) @(posedge clk_sys);
        chk(32'h0, 32'h1);
        end_sim;
    end
endmodule : test_modbus_rtu_diagnostic_echo
